// >>> rtl/mioc_pkg.sv
// Package: shared constants and types for the memory and I/O ordering block
package mioc_pkg;
  localparam int unsigned MIOC_PCI_DATA_W = 64;
  localparam int unsigned MIOC_ADDR_W = 32;
  localparam int unsigned MIOC_POST_DEPTH = 4;
  localparam int unsigned MIOC_DEV_DEPTH = 4;
  localparam int unsigned MIOC_NUM_REQ = 3;
  // Requester indices into the memory arbiter
  localparam int unsigned MIOC_REQ_CPU = 0;
  localparam int unsigned MIOC_REQ_DEV = 1;
  localparam int unsigned MIOC_REQ_TLB = 2;
  localparam logic [1:0] MIOC_RST_LAST = 2'h2;

  typedef enum logic [1:0] {
    MIOC_CMD_MEM_MISS = 2'h0,
    MIOC_CMD_IO_WRITE = 2'h1,
    MIOC_CMD_IO_READ = 2'h2,
    MIOC_CMD_BARRIER = 2'h3
  } mioc_cmd_t;

  typedef enum logic [1:0] {
    MIOC_DEV_READ = 2'h0,
    MIOC_DEV_WRITE = 2'h1,
    MIOC_DEV_TLB = 2'h2,
    MIOC_DEV_NONE = 2'h3
  } mioc_dev_t;

  typedef enum logic [1:0] {
    MIOC_PRB_READ = 2'h0,
    MIOC_PRB_FLUSH = 2'h1
  } mioc_probe_t;

  typedef enum logic [1:0] {
    MIOC_MOP_READ = 2'h0,
    MIOC_MOP_WRITE = 2'h1,
    MIOC_MOP_RMW = 2'h2
  } mioc_mop_t;
endpackage : mioc_pkg

// >>> rtl/mioc_arb_if.sv
// Interface: arbiter request and grant between core and arbiter
`timescale 1ns/100ps
interface mioc_arb_if;
  import mioc_pkg::*;
  logic [MIOC_NUM_REQ-1:0] req;
  logic [MIOC_NUM_REQ-1:0] grant;
  logic done;
  modport core (output req, output done, input grant);
  modport arb (input req, input done, output grant);
endinterface : mioc_arb_if

// >>> rtl/mioc_arbiter.sv
// Round-robin memory ownership arbiter
`timescale 1ns/100ps
module mioc_arbiter
  import mioc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  mioc_arb_if.arb arb
);
  logic [MIOC_NUM_REQ-1:0] grant_ff;
  logic [1:0] last_ff;
  logic [MIOC_NUM_REQ-1:0] nxt_grant;
  logic [1:0] idx;

  // Start search one past the last winner so no requester starves
  always_comb begin
    nxt_grant = '0;
    idx = '0;
    for (int i = 1; i <= MIOC_NUM_REQ; i++) begin
      idx = 2'((int'(last_ff) + i) % MIOC_NUM_REQ);
      if (nxt_grant == '0 && arb.req[idx]) begin
        nxt_grant[idx] = 1'b1;
      end
    end
  end

  // Ownership held until the owner reports done
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      grant_ff <= '0;
      last_ff <= MIOC_RST_LAST;
    end else if (grant_ff != '0) begin
      if (arb.done) begin
        grant_ff <= '0;
      end
    end else if (nxt_grant != '0) begin
      grant_ff <= nxt_grant;
      for (int j = 0; j < MIOC_NUM_REQ; j++) begin
        if (nxt_grant[j]) begin
          last_ff <= 2'(j);
        end
      end
    end
  end

  assign arb.grant = grant_ff;

  a_grant_onehot: assert property (@(posedge clock) disable iff (!reset_n)
    $onehot0(grant_ff)) else $error("memory granted to two owners");
  a_grant_held: assert property (@(posedge clock) disable iff (!reset_n)
    (grant_ff != '0 && !arb.done) |=> grant_ff == $past(grant_ff))
    else $error("ownership moved before owner done");
endmodule : mioc_arbiter

// >>> rtl/mioc_order.sv
// Coherency and ordering core between processor, DRAM and the 64-bit PCI bus
`timescale 1ns/100ps
// Overview of operation
// - Barrier instructions from the processor are accepted and do nothing.
// - Processor I/O read waits until all earlier posted processor I/O writes drained.
// - Device memory read waits until that device's earlier memory writes are drained.
// - Device reads of memory may pass buffered processor writes to that device.
// - DRAM performs only one access at a time.
// - Read-modify-write halves are atomic; nothing is inserted between them.
// - Miss with victim reads the block then writes victim, back to back.
// - Memory owner keeps exclusive memory until all its activity finishes.
// - TLB miss probes processor with read only after owning memory.
// - Device read probes processor with read only after owning memory.
// - Device write flush-probes after ownership; one memory write merges both data.
// - Probe-plus-memory sequences never interleave with each other.
// - The outgoing I/O bus is PCI with a 64-bit data path.
// - Processor commands are processed strictly in issue order.
// - Control register operations occur one at a time, in issue order.
// - Processor I/O commands reach PCI in emitted order.
module mioc_order
  import mioc_pkg::*;
#(
  parameter int unsigned POST_DEPTH = MIOC_POST_DEPTH,
  parameter int unsigned DEV_DEPTH = MIOC_DEV_DEPTH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cpu_cmd_valid,
  input wire mioc_cmd_t cpu_cmd,
  input wire logic cpu_victim,
  input wire logic cpu_partial,
  input wire logic [MIOC_ADDR_W-1:0] cpu_addr,
  input wire logic [MIOC_PCI_DATA_W-1:0] cpu_wdata,
  output logic cpu_cmd_ready,
  output logic cpu_cmd_done,
  input wire logic dev_req_valid,
  input wire mioc_dev_t dev_req,
  input wire logic [MIOC_ADDR_W-1:0] dev_addr,
  output logic dev_req_ready,
  output logic dev_req_done,
  input wire logic dev_wbuf_push,
  input wire logic dev_wbuf_pop,
  output logic probe_valid,
  output mioc_probe_t probe_cmd,
  output logic [MIOC_ADDR_W-1:0] probe_addr,
  input wire logic probe_ack,
  output logic mem_valid,
  output mioc_mop_t mem_op,
  output logic [MIOC_ADDR_W-1:0] mem_addr,
  input wire logic mem_done,
  output logic pci_valid,
  output logic pci_write,
  output logic [MIOC_ADDR_W-1:0] pci_addr,
  output logic [MIOC_PCI_DATA_W-1:0] pci_wdata,
  input wire logic pci_ready
);
  // ****************************************
  // Memory sequencer states
  // ****************************************
  typedef enum logic [6:0] {
    MIOC_S_IDLE = 7'h01,
    MIOC_S_WAIT = 7'h02,
    MIOC_S_PROBE = 7'h04,
    MIOC_S_MEM1 = 7'h08,
    MIOC_S_MEM2 = 7'h10,
    MIOC_S_DONE = 7'h20,
    MIOC_S_GAP = 7'h40
  } mioc_state_t;

  mioc_state_t state_ff;
  mioc_arb_if arb_bus ();
  logic [$clog2(POST_DEPTH+1)-1:0] post_cnt_ff;
  logic [$clog2(DEV_DEPTH+1)-1:0] dev_cnt_ff;
  logic cpu_mem_pend;
  logic dev_mem_pend;
  logic tlb_mem_pend;
  logic cpu_is_io_wr;
  logic cpu_is_io_rd;
  logic io_busy_ff;
  logic io_wr_ff;
  logic [MIOC_ADDR_W-1:0] io_addr_ff;
  logic [MIOC_PCI_DATA_W-1:0] io_data_ff;
  logic pci_take;
  logic owner_cpu_ff;
  logic two_phase_ff;
  mioc_mop_t op2_ff;
  logic cpu_cmd_done_ff;
  logic dev_req_done_ff;

  mioc_arbiter u_arb (
    .clock(clock),
    .reset_n(reset_n),
    .arb(arb_bus.arb)
  );

  // ****************************************
  // Processor command intake
  // ****************************************
  // One command in flight at a time keeps issue order and single register ops
  assign cpu_is_io_wr = cpu_cmd_valid && cpu_cmd == MIOC_CMD_IO_WRITE;
  assign cpu_is_io_rd = cpu_cmd_valid && cpu_cmd == MIOC_CMD_IO_READ;
  assign cpu_mem_pend = cpu_cmd_valid && cpu_cmd == MIOC_CMD_MEM_MISS && !cpu_cmd_done_ff;
  assign dev_mem_pend = dev_req_valid && dev_req != MIOC_DEV_TLB && dev_req != MIOC_DEV_NONE
    && !dev_req_done_ff && !(dev_req == MIOC_DEV_READ && dev_cnt_ff != '0);
  assign tlb_mem_pend = dev_req_valid && dev_req == MIOC_DEV_TLB && !dev_req_done_ff;
  assign arb_bus.req = {tlb_mem_pend, dev_mem_pend, cpu_mem_pend};
  assign arb_bus.done = state_ff == MIOC_S_DONE;

  // Single-entry posted write; reads wait for it, barriers retire at once
  assign pci_take = !io_busy_ff && ((cpu_is_io_wr && post_cnt_ff < POST_DEPTH)
    || (cpu_is_io_rd && post_cnt_ff == '0));

  always_comb begin
    cpu_cmd_ready = 1'b0;
    unique case (cpu_cmd)
      MIOC_CMD_BARRIER: cpu_cmd_ready = cpu_cmd_valid;
      MIOC_CMD_IO_WRITE: cpu_cmd_ready = pci_take;
      MIOC_CMD_IO_READ: cpu_cmd_ready = io_busy_ff && !io_wr_ff && pci_ready;
      MIOC_CMD_MEM_MISS: cpu_cmd_ready = cpu_cmd_done_ff;
    endcase
  end

  // ****************************************
  // PCI issue stage
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      io_busy_ff <= 1'b0;
      io_wr_ff <= 1'b0;
      io_addr_ff <= '0;
      io_data_ff <= '0;
    end else if (io_busy_ff) begin
      if (pci_ready) begin
        io_busy_ff <= 1'b0;
      end
    end else if (pci_take) begin
      io_busy_ff <= 1'b1;
      io_wr_ff <= cpu_is_io_wr;
      io_addr_ff <= cpu_addr;
      io_data_ff <= cpu_wdata;
    end
  end

  // Posted writes still owed to PCI; count rises on intake, falls on issue
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      post_cnt_ff <= '0;
    end else if ((pci_take && cpu_is_io_wr) && !(io_busy_ff && io_wr_ff && pci_ready)) begin
      post_cnt_ff <= post_cnt_ff + 1'b1;
    end else if (!(pci_take && cpu_is_io_wr) && io_busy_ff && io_wr_ff && pci_ready) begin
      post_cnt_ff <= post_cnt_ff - 1'b1;
    end
  end

  assign pci_valid = io_busy_ff;
  assign pci_write = io_wr_ff;
  assign pci_addr = io_addr_ff;
  assign pci_wdata = io_data_ff;

  // Device memory-write buffer occupancy
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dev_cnt_ff <= '0;
    end else if (dev_wbuf_push && !dev_wbuf_pop && dev_cnt_ff < DEV_DEPTH) begin
      dev_cnt_ff <= dev_cnt_ff + 1'b1;
    end else if (dev_wbuf_pop && !dev_wbuf_push && dev_cnt_ff != '0) begin
      dev_cnt_ff <= dev_cnt_ff - 1'b1;
    end
  end
  assign dev_req_ready = dev_req_done_ff;

  // ****************************************
  // Memory owner sequencer
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= MIOC_S_IDLE;
      owner_cpu_ff <= 1'b0;
      two_phase_ff <= 1'b0;
      op2_ff <= MIOC_MOP_READ;
      mem_op <= MIOC_MOP_READ;
      mem_addr <= '0;
      probe_cmd <= MIOC_PRB_READ;
      probe_addr <= '0;
    end else begin
      unique case (state_ff)
        MIOC_S_IDLE: if (arb_bus.req != '0) state_ff <= MIOC_S_WAIT;
        MIOC_S_WAIT: begin
          if (arb_bus.grant[MIOC_REQ_CPU]) begin
            owner_cpu_ff <= 1'b1;
            two_phase_ff <= cpu_victim;
            op2_ff <= MIOC_MOP_WRITE;
            mem_op <= MIOC_MOP_READ;
            mem_addr <= cpu_addr;
            state_ff <= MIOC_S_MEM1;
          end else if (arb_bus.grant != '0) begin
            owner_cpu_ff <= 1'b0;
            two_phase_ff <= 1'b0;
            probe_cmd <= (dev_req == MIOC_DEV_WRITE) ? MIOC_PRB_FLUSH : MIOC_PRB_READ;
            probe_addr <= dev_addr;
            mem_addr <= dev_addr;
            mem_op <= (dev_req == MIOC_DEV_WRITE) ? MIOC_MOP_WRITE : MIOC_MOP_READ;
            state_ff <= MIOC_S_PROBE;
          end else if (arb_bus.req == '0) begin
            state_ff <= MIOC_S_IDLE;
          end
        end
        MIOC_S_PROBE: if (probe_ack) state_ff <= MIOC_S_MEM1;
        MIOC_S_MEM1: begin
          if (mem_done) begin
            if (two_phase_ff) begin
              two_phase_ff <= 1'b0;
              mem_op <= op2_ff;
              state_ff <= MIOC_S_MEM2;
            end else begin
              state_ff <= MIOC_S_DONE;
            end
          end else if (owner_cpu_ff && cpu_partial && mem_op == MIOC_MOP_READ) begin
            mem_op <= MIOC_MOP_RMW;
          end
        end
        MIOC_S_MEM2: if (mem_done) state_ff <= MIOC_S_DONE;
        MIOC_S_DONE: state_ff <= MIOC_S_GAP;
        MIOC_S_GAP: state_ff <= MIOC_S_IDLE;
      endcase
    end
  end

  // Done pulses clear one cycle later so a held request is not rearbitrated
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cpu_cmd_done_ff <= 1'b0;
      dev_req_done_ff <= 1'b0;
    end else begin
      cpu_cmd_done_ff <= state_ff == MIOC_S_DONE && owner_cpu_ff;
      dev_req_done_ff <= state_ff == MIOC_S_DONE && !owner_cpu_ff;
    end
  end

  assign probe_valid = state_ff == MIOC_S_PROBE;
  assign mem_valid = state_ff == MIOC_S_MEM1 || state_ff == MIOC_S_MEM2;
  assign cpu_cmd_done = cpu_cmd_done_ff;
  assign dev_req_done = dev_req_done_ff;

  // ****************************************
  // Checks
  // ****************************************
  sequence s_probe_then_mem;
    probe_valid ##[1:1000] mem_valid;
  endsequence
  sequence s_probe_taken;
    probe_valid && probe_ack;
  endsequence
  a_probe_after_own: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(probe_valid) |-> arb_bus.grant != '0) else $error("probe before ownership");
  a_probe_mem_seq: assert property (@(posedge clock) disable iff (!reset_n)
    s_probe_taken |=> mem_valid) else $error("probe not followed by memory");
  a_probe_reaches_mem: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(probe_valid) |-> s_probe_then_mem) else $error("probe never reached memory");
  a_flush_merge: assert property (@(posedge clock) disable iff (!reset_n)
    probe_valid && probe_cmd == MIOC_PRB_FLUSH |-> mem_op == MIOC_MOP_WRITE)
    else $error("flush probe without merged write");
  a_seq_atomic: assert property (@(posedge clock) disable iff (!reset_n)
    probe_valid |-> !mem_valid && $onehot(arb_bus.grant) && !arb_bus.grant[MIOC_REQ_CPU])
    else $error("probe overlapped memory cycle");
  a_victim_b2b: assert property (@(posedge clock) disable iff (!reset_n)
    state_ff == MIOC_S_MEM1 && mem_done && two_phase_ff |=> mem_valid && mem_op == MIOC_MOP_WRITE)
    else $error("victim write not back to back");
  a_io_read_drain: assert property (@(posedge clock) disable iff (!reset_n)
    pci_valid && !pci_write |-> post_cnt_ff == '0) else $error("io read passed posted write");
  a_dev_read_drain: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(probe_valid) && probe_cmd == MIOC_PRB_READ && !tlb_mem_pend |-> dev_cnt_ff == '0)
    else $error("device read passed its writes");
  a_barrier_nop: assert property (@(posedge clock) disable iff (!reset_n)
    cpu_cmd_valid && cpu_cmd == MIOC_CMD_BARRIER |-> cpu_cmd_ready && !$rose(pci_valid))
    else $error("barrier not retired as no-op");
  a_pci_hold: assert property (@(posedge clock) disable iff (!reset_n)
    pci_valid && !pci_ready |=> pci_valid && $stable(pci_addr))
    else $error("pci command dropped or reordered");
endmodule : mioc_order

// >>> verif/mioc_far_model.sv
// Far-side model: processor probe responder, DRAM responder and PCI target
`timescale 1ns/100ps
module mioc_far_resp (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic req,
  input wire logic [5:0] delay,
  output logic ack
);
  logic [5:0] cnt_ff;
  // Ack is a one-cycle pulse, so a request held across two operations gets two answers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 6'h0;
      ack <= 1'b0;
    end else if (req && !ack && cnt_ff == delay) begin
      ack <= 1'b1;
      cnt_ff <= 6'h0;
    end else begin
      ack <= 1'b0;
      cnt_ff <= (req && !ack) ? cnt_ff + 6'h1 : 6'h0;
    end
  end
endmodule : mioc_far_resp

module mioc_far_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic probe_valid,
  output logic probe_ack,
  input wire logic mem_valid,
  output logic mem_done,
  input wire logic pci_valid,
  output logic pci_ready
);
  // Slow mode keeps the PCI target busy long enough for posted writes to linger
  mioc_far_resp u_prb (.clock(clock), .reset_n(reset_n), .req(probe_valid),
    .delay(slow ? 6'h5 : 6'h1), .ack(probe_ack));
  mioc_far_resp u_mem (.clock(clock), .reset_n(reset_n), .req(mem_valid),
    .delay(slow ? 6'h4 : 6'h2), .ack(mem_done));
  mioc_far_resp u_pci (.clock(clock), .reset_n(reset_n), .req(pci_valid),
    .delay(slow ? 6'h28 : 6'h1), .ack(pci_ready));
endmodule : mioc_far_model

// >>> verif/memory_io_coherency_ordering_tb_top.sv
// Testbench top for the memory and I/O ordering core
`timescale 1ns/100ps
module memory_io_coherency_ordering_tb_top;
  import mioc_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, slow = 1'b0;
  logic cpu_cmd_valid = 1'b0, cpu_victim = 1'b0, cpu_partial = 1'b0;
  mioc_cmd_t cpu_cmd = MIOC_CMD_BARRIER;
  logic [31:0] cpu_addr = 32'h0, dev_addr = 32'h0, probe_addr, mem_addr, pci_addr, last_pa;
  logic [63:0] cpu_wdata = 64'h0, pci_wdata, last_wd;
  logic cpu_cmd_ready, cpu_cmd_done, dev_req_valid = 1'b0, dev_req_ready, dev_req_done;
  mioc_dev_t dev_req = MIOC_DEV_NONE;
  logic dev_wbuf_push = 1'b0, dev_wbuf_pop = 1'b0, probe_valid, probe_ack;
  mioc_probe_t probe_cmd;
  mioc_mop_t mem_op;
  logic mem_valid, mem_done, pci_valid, pci_write, pci_ready;
  logic [7:0] ev[$];
  int n_errors = 0, n_compared = 0, n_done = 0;
  always #4 clock = ~clock;
  mioc_order u_mioc_order (.clock(clock), .reset_n(reset_n), .cpu_cmd_valid(cpu_cmd_valid),
    .cpu_cmd(cpu_cmd), .cpu_victim(cpu_victim), .cpu_partial(cpu_partial),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_cmd_ready(cpu_cmd_ready),
    .cpu_cmd_done(cpu_cmd_done), .dev_req_valid(dev_req_valid), .dev_req(dev_req),
    .dev_addr(dev_addr), .dev_req_ready(dev_req_ready), .dev_req_done(dev_req_done),
    .dev_wbuf_push(dev_wbuf_push), .dev_wbuf_pop(dev_wbuf_pop), .probe_valid(probe_valid),
    .probe_cmd(probe_cmd), .probe_addr(probe_addr), .probe_ack(probe_ack),
    .mem_valid(mem_valid), .mem_op(mem_op), .mem_addr(mem_addr), .mem_done(mem_done),
    .pci_valid(pci_valid), .pci_write(pci_write), .pci_addr(pci_addr),
    .pci_wdata(pci_wdata), .pci_ready(pci_ready));
  mioc_far_model u_mioc_far_model (.clock(clock), .reset_n(reset_n), .slow(slow),
    .probe_valid(probe_valid), .probe_ack(probe_ack), .mem_valid(mem_valid),
    .mem_done(mem_done), .pci_valid(pci_valid), .pci_ready(pci_ready));
  // ****************************************
  // Event log: probes 2x, memory 1x, PCI 3x
  // ****************************************
  always @(posedge clock) begin
    if (probe_valid && probe_ack) ev.push_back({6'h08, probe_cmd});
    if (mem_valid && mem_done) ev.push_back({6'h04, mem_op});
    if (pci_valid && pci_ready) ev.push_back({7'h18, pci_write});
    if (pci_valid && pci_ready && pci_write) last_wd = pci_wdata;
    if (pci_valid && pci_ready) last_pa = pci_addr;
    if (cpu_cmd_done) n_done++;
  end
  function automatic logic [7:0] pop_ev();
    if (ev.size() == 0) return 8'hff;
    return ev.pop_front();
  endfunction : pop_ev
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic hang();
    n_errors++;
    $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  endtask : hang
  task automatic cpu_do(input mioc_cmd_t c, input logic v, input logic p, output int i);
    @(posedge clock);
    #1;
    cpu_cmd = c;
    cpu_victim = v;
    cpu_partial = p;
    cpu_addr = cpu_addr + 32'h40;
    cpu_wdata = {cpu_addr, ~cpu_addr};
    cpu_cmd_valid = 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      if (cpu_cmd_ready === 1'b1) break;
    end
    #1;
    cpu_cmd_valid = 1'b0;
    if (i == 300) hang();
  endtask : cpu_do
  task automatic dev_go(input mioc_dev_t k, input logic [31:0] a);
    @(posedge clock);
    #1;
    dev_req = k;
    dev_addr = a;
    dev_req_valid = 1'b1;
  endtask : dev_go
  task automatic dev_wait();
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clock);
      if (dev_req_done === 1'b1) break;
    end
    if (i < 300) cmp(dev_req_ready, 1'b1);
    #1;
    dev_req_valid = 1'b0;
    if (i == 300) hang();
  endtask : dev_wait
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_barrier();
    int i;
    cpu_do(MIOC_CMD_BARRIER, 1'b0, 1'b0, i);
    cmp(i, 0);
    repeat (10) @(posedge clock);
    cmp(ev.size(), 0);
    $display("test barrier done");
  endtask : t_barrier
  task automatic t_io_order();
    int i;
    logic [63:0] wd;
    cpu_do(MIOC_CMD_IO_WRITE, 1'b0, 1'b0, i);
    wd = cpu_wdata;
    cmp(i, 0);
    cpu_do(MIOC_CMD_IO_READ, 1'b0, 1'b0, i);
    cmp(pop_ev(), 8'h31);
    cmp(pop_ev(), 8'h30);
    cmp(last_pa, cpu_addr);
    cmp(last_wd, wd);
    $display("test io order done");
  endtask : t_io_order
  task automatic t_miss();
    int i, d0;
    d0 = n_done;
    cpu_do(MIOC_CMD_MEM_MISS, 1'b1, 1'b0, i);
    cmp(pop_ev(), 8'h10);
    cmp(pop_ev(), 8'h11);
    cpu_do(MIOC_CMD_MEM_MISS, 1'b0, 1'b1, i);
    cmp(pop_ev(), 8'h12);
    cmp(n_done - d0, 2);
    $display("test miss done");
  endtask : t_miss
  task automatic t_dev_kinds();
    mioc_dev_t k[3] = '{MIOC_DEV_READ, MIOC_DEV_WRITE, MIOC_DEV_TLB};
    logic [7:0] pe[3] = '{8'h20, 8'h21, 8'h20};
    logic [7:0] me[3] = '{8'h10, 8'h11, 8'h10};
    for (int j = 0; j < 3; j++) begin
      dev_go(k[j], 32'h1000 + j * 32'h40);
      dev_wait();
      cmp(pop_ev(), pe[j]);
      cmp(pop_ev(), me[j]);
      cmp(mem_addr, 32'h1000 + j * 32'h40);
      cmp(probe_addr, 32'h1000 + j * 32'h40);
    end
    $display("test device kinds done");
  endtask : t_dev_kinds
  task automatic t_dev_wbuf();
    @(posedge clock);
    #1;
    dev_wbuf_push = 1'b1;
    @(posedge clock);
    #1;
    dev_wbuf_push = 1'b0;
    dev_go(MIOC_DEV_READ, 32'h2000);
    repeat (20) @(posedge clock);
    cmp({ev.size(), dev_req_done}, 0);
    #1;
    dev_wbuf_pop = 1'b1;
    @(posedge clock);
    #1;
    dev_wbuf_pop = 1'b0;
    dev_wait();
    cmp(pop_ev(), 8'h20);
    cmp(pop_ev(), 8'h10);
    $display("test write buffer drain done");
  endtask : t_dev_wbuf
  task automatic t_post_pass();
    int i;
    slow = 1'b1;
    cpu_do(MIOC_CMD_IO_WRITE, 1'b0, 1'b0, i);
    dev_go(MIOC_DEV_READ, 32'h3000);
    dev_wait();
    cmp(pop_ev(), 8'h20);
    cmp(pop_ev(), 8'h10);
    for (i = 0; i < 200 && ev.size() == 0; i++) @(posedge clock);
    if (i == 200) hang();
    cmp(pop_ev(), 8'h31);
    slow = 1'b0;
    $display("test posted pass done");
  endtask : t_post_pass
  task automatic t_atomic_mix();
    int i;
    logic [7:0] e0;
    fork
      cpu_do(MIOC_CMD_MEM_MISS, 1'b1, 1'b0, i);
      begin
        dev_go(MIOC_DEV_WRITE, 32'h4000);
        dev_wait();
      end
    join
    e0 = pop_ev();
    cmp(e0, 8'h10);
    cmp(pop_ev(), 8'h11);
    cmp(pop_ev(), (e0 == 8'h21) ? 8'h10 : 8'h21);
    cmp(pop_ev(), 8'h11);
    $display("test atomic mix done");
  endtask : t_atomic_mix
  initial begin
    repeat (3) @(posedge clock);
    cmp({mem_valid, probe_valid, pci_valid, cpu_cmd_done}, 0);
    #1;
    reset_n = 1'b1;
    t_barrier();
    t_io_order();
    t_miss();
    t_dev_kinds();
    t_dev_wbuf();
    t_post_pass();
    t_atomic_mix();
    end_sim();
  end
endmodule : memory_io_coherency_ordering_tb_top
